// [csc_consts.svh]
// register offsets, field positions, reset values and timing counts for the conversion control block
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_IDX_ONE_SHOT      8'h01
`define CSC_IDX_RANGE         8'h02
`define CSC_IDX_POWER_DOWN    8'h03
`define CSC_RST_ONE_SHOT      8'h02
`define CSC_RST_RANGE         8'h22
`define CSC_RST_POWER_DOWN    8'h00
`define CSC_BIT_TRIGGER       0
`define CSC_BIT_MODE_ENABLE   1
`define CSC_LSB_CH1_RANGE     0
`define CSC_LSB_CH2_RANGE     4
`define CSC_BIT_CH1_PD        1
`define CSC_BIT_CH2_PD        2
`define CSC_WAIT_STATES       1
`endif

// [csc_pkg.sv]
// types shared by the conversion control block
package csc_pkg;
  typedef enum logic [2:0] {
    CSC_IDLE  = 3'b001,
    CSC_START = 3'b010,
    CSC_BUSY  = 3'b100
  } csc_conv_state_t;

  typedef enum logic [1:0] {
    CSC_FS_5PF  = 2'h0,
    CSC_FS_10PF = 2'h1,
    CSC_FS_20PF = 2'h2
  } csc_full_scale_t;

  typedef struct packed {
    logic            waitrequest;
    logic [31:0]     readdata;
    logic            one_shot_mode_enable;
    logic            one_shot_trigger;
    logic [1:0]      ch1_full_scale_select;
    logic [1:0]      ch2_full_scale_select;
    logic            ch1_power_down;
    logic            ch2_power_down;
    csc_conv_state_t conv_state;
    logic            conv_start;
    logic            ch1_convert;
    logic            ch2_convert;
    csc_full_scale_t ch1_full_scale;
    csc_full_scale_t ch2_full_scale;
  } csc_state_t;
endpackage : csc_pkg

// [csc_conversion_control.sv]
// single-conversion trigger, range select and channel power-down registers behind an avalon-mm slave
`timescale 1ns/1ps
`include "csc_consts.svh"

module csc_conversion_control #(
  parameter int ADDR_W = 4    // byte address width
) (
  input  wire logic              ref_clk,        // 50 mhz system clock
  input  wire logic              reset,          // synchronous, active high
  input  wire logic [ADDR_W-1:0] address,        // avalon byte address
  input  wire logic              read,           // avalon read request
  input  wire logic              write,          // avalon write request
  input  wire logic [3:0]        byteenable,     // avalon byte lanes
  input  wire logic [31:0]       writedata,      // avalon write data
  output logic [31:0]            readdata,       // avalon read data
  output logic                   waitrequest,    // avalon stall, low marks the answer
  input  wire logic              conv_done,      // front end finished the conversion, pulse
  output logic                   conv_start,     // one-cycle start to the front end
  output logic                   ch1_convert,    // channel 1 takes part in this conversion
  output logic                   ch2_convert,    // channel 2 takes part in this conversion
  output logic                   ch1_power_down, // channel 1 analog power-down
  output logic                   ch2_power_down, // channel 2 analog power-down
  output logic [1:0]             ch1_full_scale, // 0 5pf, 1 10pf, 2 20pf
  output logic [1:0]             ch2_full_scale  // 0 5pf, 1 10pf, 2 20pf
);

  generate
    if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must be at least 4 to reach all registers");
    end
    // the register index is eight bits wide, so wider addresses cannot be decoded
    if (ADDR_W > 8) begin : g_addr_max_check
      $error("ADDR_W must be at most 8");
    end
  endgenerate

  csc_pkg::csc_state_t state;
  csc_pkg::csc_state_t next_state;

  // word index times four gives the byte address
  function automatic logic csc_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    logic [ADDR_W+1:0] byte_addr;
    byte_addr = {idx[ADDR_W-1:0], 2'b00};
    csc_hit = (addr == byte_addr[ADDR_W-1:0]);
  endfunction : csc_hit

  // both 10 and 11 select the largest range
  function automatic csc_pkg::csc_full_scale_t csc_decode(input logic [1:0] code);
    if (code[1]) begin
      csc_decode = csc_pkg::CSC_FS_20PF;
    end else if (code[0]) begin
      csc_decode = csc_pkg::CSC_FS_10PF;
    end else begin
      csc_decode = csc_pkg::CSC_FS_5PF;
    end
  endfunction : csc_decode

  logic       bus_req;
  logic       wr_take;
  logic       any_channel;
  logic [7:0] rst_one_shot;
  logic [7:0] rst_range;
  logic [7:0] rst_pd;

  assign rst_one_shot = `CSC_RST_ONE_SHOT;
  assign rst_range    = `CSC_RST_RANGE;
  assign rst_pd       = `CSC_RST_POWER_DOWN;
  assign bus_req      = read | write;
  // write lands only at the edge where waitrequest is seen low
  assign wr_take      = write & ~state.waitrequest & byteenable[0];
  assign any_channel  = ~state.ch1_power_down | ~state.ch2_power_down;

  always_comb begin
    next_state = state;
    next_state.conv_start = 1'b0;

    // one wait state, then answer; registered readdata lines up with it
    next_state.waitrequest = ~(bus_req & state.waitrequest);
    next_state.readdata    = 32'h0000_0000;
    if (read & state.waitrequest) begin
      if (csc_hit(address, `CSC_IDX_ONE_SHOT)) begin
        next_state.readdata[`CSC_BIT_TRIGGER]     = state.one_shot_trigger;
        next_state.readdata[`CSC_BIT_MODE_ENABLE] = state.one_shot_mode_enable;
      end else if (csc_hit(address, `CSC_IDX_RANGE)) begin
        next_state.readdata[`CSC_LSB_CH1_RANGE +: 2] = state.ch1_full_scale_select;
        next_state.readdata[`CSC_LSB_CH2_RANGE +: 2] = state.ch2_full_scale_select;
      end else if (csc_hit(address, `CSC_IDX_POWER_DOWN)) begin
        next_state.readdata[`CSC_BIT_CH1_PD] = state.ch1_power_down;
        next_state.readdata[`CSC_BIT_CH2_PD] = state.ch2_power_down;
      end
    end

    if (wr_take) begin
      if (csc_hit(address, `CSC_IDX_ONE_SHOT)) begin
        next_state.one_shot_mode_enable = writedata[`CSC_BIT_MODE_ENABLE];
        // a pending trigger can be neither cancelled nor restarted
        if (!state.one_shot_trigger && writedata[`CSC_BIT_TRIGGER] && writedata[`CSC_BIT_MODE_ENABLE]) begin
          next_state.one_shot_trigger = 1'b1;
        end
      end else if (csc_hit(address, `CSC_IDX_RANGE)) begin
        next_state.ch1_full_scale_select = writedata[`CSC_LSB_CH1_RANGE +: 2];
        next_state.ch2_full_scale_select = writedata[`CSC_LSB_CH2_RANGE +: 2];
      end else if (csc_hit(address, `CSC_IDX_POWER_DOWN)) begin
        next_state.ch1_power_down = writedata[`CSC_BIT_CH1_PD];
        next_state.ch2_power_down = writedata[`CSC_BIT_CH2_PD];
      end
    end

    next_state.ch1_full_scale = csc_decode(state.ch1_full_scale_select);
    next_state.ch2_full_scale = csc_decode(state.ch2_full_scale_select);

    case (state.conv_state)
      csc_pkg::CSC_IDLE: begin
        if (state.one_shot_trigger && state.one_shot_mode_enable) begin
          if (any_channel) begin
            next_state.conv_state  = csc_pkg::CSC_START;
            next_state.conv_start  = 1'b1;
            next_state.ch1_convert = ~state.ch1_power_down;
            next_state.ch2_convert = ~state.ch2_power_down;
          end else begin
            // nothing to convert, so the conversion ends at once
            next_state.one_shot_trigger = 1'b0;
          end
        end
      end
      csc_pkg::CSC_START: begin
        next_state.conv_state = csc_pkg::CSC_BUSY;
      end
      csc_pkg::CSC_BUSY: begin
        // done before start-plus-one is not expected from the front end
        if (conv_done) begin
          next_state.conv_state       = csc_pkg::CSC_IDLE;
          next_state.one_shot_trigger = 1'b0;
          next_state.ch1_convert      = 1'b0;
          next_state.ch2_convert      = 1'b0;
        end
      end
      default: begin
        next_state.conv_state = csc_pkg::CSC_IDLE;
      end
    endcase

    if (reset) begin
      next_state.waitrequest           = 1'b1;
      next_state.readdata              = 32'h0000_0000;
      next_state.one_shot_trigger      = rst_one_shot[`CSC_BIT_TRIGGER];
      next_state.one_shot_mode_enable  = rst_one_shot[`CSC_BIT_MODE_ENABLE];
      next_state.ch1_full_scale_select = rst_range[`CSC_LSB_CH1_RANGE +: 2];
      next_state.ch2_full_scale_select = rst_range[`CSC_LSB_CH2_RANGE +: 2];
      next_state.ch1_power_down        = rst_pd[`CSC_BIT_CH1_PD];
      next_state.ch2_power_down        = rst_pd[`CSC_BIT_CH2_PD];
      next_state.conv_state            = csc_pkg::CSC_IDLE;
      next_state.conv_start            = 1'b0;
      next_state.ch1_convert           = 1'b0;
      next_state.ch2_convert           = 1'b0;
      next_state.ch1_full_scale        = csc_decode(rst_range[`CSC_LSB_CH1_RANGE +: 2]);
      next_state.ch2_full_scale        = csc_decode(rst_range[`CSC_LSB_CH2_RANGE +: 2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  assign readdata       = state.readdata;
  assign waitrequest    = state.waitrequest;
  assign conv_start     = state.conv_start;
  assign ch1_convert    = state.ch1_convert;
  assign ch2_convert    = state.ch2_convert;
  assign ch1_power_down = state.ch1_power_down;
  assign ch2_power_down = state.ch2_power_down;
  assign ch1_full_scale = state.ch1_full_scale;
  assign ch2_full_scale = state.ch2_full_scale;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_reset_loads_02: assert property ($past(reset) |-> state.one_shot_mode_enable && !state.one_shot_trigger)
    else $error("one-shot register not 02h after reset");

  a_trigger_starts: assert property (
    (state.conv_state == csc_pkg::CSC_IDLE) && state.one_shot_trigger && state.one_shot_mode_enable && any_channel
    |=> conv_start ##1 !conv_start)
    else $error("trigger did not give one start pulse");

  a_trigger_sticky: assert property (
    state.one_shot_trigger && !((state.conv_state == csc_pkg::CSC_BUSY) && conv_done)
    && !((state.conv_state == csc_pkg::CSC_IDLE) && !any_channel && state.one_shot_mode_enable)
    |=> state.one_shot_trigger)
    else $error("pending trigger was cancelled");

  a_done_clears: assert property ((state.conv_state == csc_pkg::CSC_BUSY) && conv_done
    |=> !state.one_shot_trigger && (state.conv_state == csc_pkg::CSC_IDLE))
    else $error("trigger not cleared at end of conversion");

  a_mode_gates: assert property (!state.one_shot_mode_enable && (state.conv_state == csc_pkg::CSC_IDLE)
    |=> !conv_start)
    else $error("conversion started with one-shot mode off");

  a_off_no_set: assert property (wr_take && csc_hit(address, `CSC_IDX_ONE_SHOT) && !writedata[1]
    && !state.one_shot_trigger |=> !state.one_shot_trigger)
    else $error("trigger set while mode disabled");

  a_reserved_zero: assert property (!waitrequest && $past(read) && $past(csc_hit(address, `CSC_IDX_ONE_SHOT))
    |-> readdata[31:2] == 30'h0)
    else $error("reserved one-shot bits read nonzero");

  a_ch1_decode: assert property (!$past(reset) |-> ch1_full_scale == csc_decode($past(state.ch1_full_scale_select)))
    else $error("channel 1 full scale decode wrong");

  a_ch2_write: assert property (wr_take && csc_hit(address, `CSC_IDX_RANGE)
    |=> state.ch2_full_scale_select == $past(writedata[5:4]))
    else $error("channel 2 range not written from bits 5:4");

  a_ch2_decode: assert property (!$past(reset) |-> ch2_full_scale == csc_decode($past(state.ch2_full_scale_select)))
    else $error("channel 2 full scale decode wrong");

  a_pd_excludes: assert property (conv_start |-> ch1_convert == !ch1_power_down
    && ch2_convert == !ch2_power_down)
    else $error("powered-down channel joined a conversion");

  a_bus_answer: assert property (bus_req && waitrequest |=> !waitrequest)
    else $error("bus answer not one wait state");

  a_answer_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_readdata_idle: assert property (waitrequest |-> readdata == 32'h0000_0000)
    else $error("readdata nonzero outside an answer");

  a_range_reserved: assert property (!waitrequest && $past(read) && $past(csc_hit(address, `CSC_IDX_RANGE))
    |-> (readdata[31:6] == 26'h0) && (readdata[3:2] == 2'h0))
    else $error("reserved range bits read nonzero");

  a_pd_reserved: assert property (!waitrequest && $past(read) && $past(csc_hit(address, `CSC_IDX_POWER_DOWN))
    |-> (readdata[31:3] == 29'h0) && !readdata[0])
    else $error("reserved power-down bits read nonzero");

  a_unmapped_zero: assert property (!waitrequest && $past(read)
    && !$past(csc_hit(address, `CSC_IDX_ONE_SHOT)) && !$past(csc_hit(address, `CSC_IDX_RANGE))
    && !$past(csc_hit(address, `CSC_IDX_POWER_DOWN)) |-> readdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  a_mode_write: assert property (wr_take && csc_hit(address, `CSC_IDX_ONE_SHOT)
    |=> state.one_shot_mode_enable == $past(writedata[`CSC_BIT_MODE_ENABLE]))
    else $error("mode bit not taken from the write");

  a_no_restart: assert property (state.conv_state != csc_pkg::CSC_IDLE |=> !conv_start)
    else $error("second start while a conversion runs");

  a_convert_holds: assert property ((state.conv_state == csc_pkg::CSC_BUSY) && !conv_done
    |=> $stable(ch1_convert) && $stable(ch2_convert))
    else $error("channel selection changed mid conversion");

  // a write with lane 0 off is acked but must leave the range, mode and power-down fields alone
  a_lane_drop: assert property (write && !waitrequest && !byteenable[0]
    |=> $stable(state.ch1_full_scale_select) && $stable(state.ch2_full_scale_select)
    && $stable(state.one_shot_mode_enable) && $stable(state.ch1_power_down) && $stable(state.ch2_power_down))
    else $error("write with lane 0 disabled changed a register");

  c_full_conversion: cover property (conv_start ##[1:20] ((state.conv_state == csc_pkg::CSC_BUSY) && conv_done));
  c_ignored_write: cover property (wr_take && state.one_shot_trigger && csc_hit(address, `CSC_IDX_ONE_SHOT));
  c_no_channel: cover property (state.one_shot_trigger && !any_channel ##1 !state.one_shot_trigger);
  c_range_write: cover property (wr_take && csc_hit(address, `CSC_IDX_RANGE) && writedata[5]);
  c_lane_drop: cover property (write && !waitrequest && !byteenable[0]);

endmodule : csc_conversion_control

// [csc_front_end_model.sv]
// behavioural front end: answers each conversion start with a done pulse
`timescale 1ns/1ps
module csc_front_end_model (
  input  wire logic       ref_clk,    // system clock
  input  wire logic       reset,      // synchronous, active high
  input  wire logic       conv_start, // start pulse from the block
  input  wire logic [7:0] delay,      // countdown length; done rises delay plus two cycles after start, set by the bench
  output logic            conv_done   // one-cycle completion pulse
);
  logic [7:0] cnt;
  logic       busy;
  always_ff @(posedge ref_clk) begin
    conv_done <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      cnt  <= 8'h00;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt  <= delay;
    end else if (busy && cnt == 8'h00) begin
      busy      <= 1'b0;
      conv_done <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule : csc_front_end_model

// [tb.sv]
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] q;
  logic        waitrequest, conv_done, conv_start, ch1_convert, ch2_convert, ch1_power_down, ch2_power_down;
  logic [1:0]  ch1_full_scale, ch2_full_scale;
  logic [1:0]  cv = 2'h0;
  logic [7:0]  fe_delay = 8'h14;
  logic [3:0]  be = 4'hf;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_starts = 0;
  int          k;

  csc_conversion_control dut (.ref_clk, .reset, .address, .read, .write, .byteenable(be), .writedata,
    .readdata, .waitrequest, .conv_done, .conv_start, .ch1_convert, .ch2_convert, .ch1_power_down,
    .ch2_power_down, .ch1_full_scale, .ch2_full_scale);
  csc_front_end_model fe (.ref_clk, .reset, .conv_start, .delay(fe_delay), .conv_done);

  initial forever #10 ref_clk = ~ref_clk;

  // remembers which channels took part in the latest start
  always @(posedge ref_clk) if (conv_start === 1'b1) begin
    n_starts <= n_starts + 1;
    cv       <= {ch2_convert, ch1_convert};
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address   <= a;
    writedata <= {24'h0, d};
    write     <= w;
    read      <= ~w;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    q = readdata;
    if (n >= 20) begin
      n_fail++;
      $display("ERROR t=%0t bus answer timed out", $time);
    end
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // polls the trigger bit until hardware drops it
  task automatic poll_clear;
    bus(1'b0, 4'h4, 8'h00);
    for (int i = 0; i < 40 && q[0] !== 1'b0; i++) bus(1'b0, 4'h4, 8'h00);
  endtask : poll_clear

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h02);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h22);
    chk({ch2_full_scale, ch1_full_scale}, 32'ha);
    bus(1'b0, 4'hc, 8'h00);
    chk(q, 32'h00);
    bus(1'b0, 4'h0, 8'h00);
    chk(q, 32'h00);
    bus(1'b1, 4'h8, 8'hff);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h33);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 4'h8, {2'h0, 2'(3 - k), 2'h0, 2'(k)});
      repeat (2) @(posedge ref_clk);
      chk(ch1_full_scale, (k > 1) ? 2 : k);
      chk(ch2_full_scale, (k < 2) ? 2 : 3 - k);
    end
    // lane 0 off: acked, nothing changes
    be <= 4'he;
    bus(1'b1, 4'h8, 8'h00);
    be <= 4'hf;
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h03);
    // trigger with the mode bit clear in the same write must not stick
    bus(1'b1, 4'h4, 8'hfd);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h00);
    bus(1'b1, 4'h4, 8'h01);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h00);
    chk(n_starts, 0);
    bus(1'b1, 4'hc, 8'h04);
    repeat (2) @(posedge ref_clk);
    chk({ch2_power_down, ch1_power_down}, 32'h2);
    bus(1'b0, 4'hc, 8'h00);
    chk(q, 32'h04);
    // slow front end: clear and restart attempts while pending
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h03);
    bus(1'b1, 4'h4, 8'h02);
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h03);
    poll_clear();
    chk(q, 32'h02);
    chk(n_starts, 1);
    chk(cv, 32'h1);
    fe_delay <= 8'h01;
    bus(1'b1, 4'hc, 8'h00);
    bus(1'b1, 4'h4, 8'h03);
    poll_clear();
    chk(q, 32'h02);
    chk(cv, 32'h3);
    bus(1'b1, 4'hc, 8'h06);
    bus(1'b1, 4'h4, 8'h03);
    poll_clear();
    chk(n_starts, 2);
    bus(1'b1, 4'h4, 8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h02);
    tally_and_finish();
  end
endmodule : tb
